/* File: bench/front_end_model.sv */
// front end and pin model: a held level on the aux slot, a pin that floats to a set level
// assumes the bench sets abLevel and pinLevel; the pin has no pull, so pinLevel decides it while gpioOe is low
`timescale 1ns/1ps
module front_end_model
  import touch_ctl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [2:0]  frontChannel,
  input  wire logic [11:0] abLevel,
  input  wire logic        pinLevel,
  input  wire logic        gpioOut,
  input  wire logic        gpioOe,
  output logic [11:0]      sampleIn = 12'h000,
  output logic             gpioIn
);
  // other slots toggle each cycle, so a stale aux value cannot stay steady; it comes back every second cycle
  always @(posedge sys_clk)
    sampleIn <= (frontChannel == AB_SLOT) ? abLevel : ~sampleIn;
  assign gpioIn = gpioOe ? gpioOut : pinLevel;
endmodule

/* File: bench/tb_touch_adc_limit_gpio_regs.sv */
// self-checking bench: registers, pin, limit alarm and sequencer timing
// assumes default settle parameters; settle code 0 keeps runs short
`timescale 1ns/1ps
module tb_touch_adc_limit_gpio_regs
  import touch_ctl_pkg::*;
();
  logic        sys_clk;
  logic        rst_n;
  reg_req_t    regReq;
  logic [15:0] regRdata;
  logic [11:0] sampleIn;
  logic [11:0] abLevel;
  logic [2:0]  frontChannel;
  logic        gpioIn, gpioOut, gpioOe, pinLevel;
  logic        frontAcquire, frontConvert, seqBusy, irqOut_n;
  int          errTotal, checkCount, cycles;

  touch_adc_limit_gpio_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
    .regRdata(regRdata), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .sampleIn(sampleIn), .frontChannel(frontChannel), .frontAcquire(frontAcquire),
    .frontConvert(frontConvert), .seqBusy(seqBusy), .irqOut_n(irqOut_n));
  front_end_model fem (.sys_clk(sys_clk), .frontChannel(frontChannel), .abLevel(abLevel),
    .pinLevel(pinLevel), .gpioOut(gpioOut), .gpioOe(gpioOe), .sampleIn(sampleIn),
    .gpioIn(gpioIn));

  task automatic completeRun();
    if (errTotal == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bit1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic waitN(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // only in-range addresses are ever written
  task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    regReq.wr <= 1'b0;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    regReq.rd <= 1'b0;
    #1 chk(regRdata & m, exp);
  endtask

  // counts acquire, convert and the rest while busy; the rest is settling plus sort
  task automatic runSeq(input logic [15:0] c1, input int acqE, input int convE,
                        input int pulses, input int restE);
    int acquisition_time, conv, busy, n;
    logic prev;
    acquisition_time = 0;
    conv = 0;
    busy = 0;
    n = 0;
    prev = 1'b0;
    wrReg(OFS_CTL_ONE, c1);
    waitN(1);
    while (seqBusy === 1'b1 && busy < 8000)
    begin
      busy++;
      if (frontAcquire === 1'b1) acquisition_time++;
      if (frontConvert === 1'b1) conv++;
      if (frontConvert === 1'b1 && !prev) n++;
      prev = (frontConvert === 1'b1);
      waitN(1);
    end
    chk(acquisition_time[15:0], acqE[15:0]);
    chk(conv[15:0], convE[15:0]);
    chk(n[15:0], pulses[15:0]);
    bit1((busy - acquisition_time - conv >= restE) && (busy - acquisition_time - conv < restE + 12), 1'b1);
  endtask

  task automatic resetMap();
    for (int i = 0; i < 14; i++)
      rdChk(i[3:0], (i == 2) ? CTL_TWO_RST : ZERO_RST, 16'hFFFF);
    rdChk(4'hF, 16'h0000, 16'hFFFF);
    wrReg(OFS_RES_BASE + 4'h4, 16'hFFFF);
    rdChk(OFS_RES_BASE + 4'h4, 16'h0000, 16'hFFFF);
  endtask

  task automatic pinOutput();
    for (int i = 0; i < 4; i++)
    begin
      wrReg(OFS_CTL_TWO, 16'h2000 | (16'(i[1]) << C2_PIN_POLARITY_BIT) | (16'(i[0]) << C2_GPIO_DAT));
      waitN(3);
      bit1(gpioOe, 1'b1);
      bit1(gpioOut, i[1] ? i[0] : ~i[0]);
    end
    wrReg(OFS_CTL_TWO, 16'h1400);
    waitN(3);
    bit1(gpioOe, 1'b0);
  endtask

  task automatic pinInput();
    wrReg(OFS_CTL_ONE, 16'h8000);
    wrReg(OFS_CTL_TWO, 16'h2C00);
    pinLevel <= 1'b1;
    waitN(6);
    bit1(gpioOe, 1'b0);
    rdChk(OFS_CTL_TWO, 16'h1000, 16'h1000);
    bit1(irqOut_n, 1'b0);
    pinLevel <= 1'b0;
    waitN(6);
    bit1(irqOut_n, 1'b1);
    wrReg(OFS_CTL_TWO, 16'h3C00);
    rdChk(OFS_CTL_TWO, 16'h0000, 16'h1000);
    wrReg(OFS_CTL_TWO, 16'h2800);
    waitN(6);
    rdChk(OFS_CTL_TWO, 16'h1000, 16'h1000);
    bit1(irqOut_n, 1'b0);
    wrReg(OFS_CTL_THR, 16'h1000);
    waitN(3);
    bit1(irqOut_n, 1'b1);
    wrReg(OFS_CTL_THR, 16'h0000);
    waitN(3);
    bit1(irqOut_n, 1'b0);
    wrReg(OFS_CTL_TWO, 16'h0800);
    waitN(6);
    bit1(irqOut_n, 1'b1);
  endtask

  task automatic limits();
    wrReg(OFS_AB_UPPER, 16'h0100);
    wrReg(OFS_AB_LOWER, 16'h0050);
    wrReg(OFS_CTL_THR, 16'h0300);
    abLevel <= 12'h200;
    runSeq(16'hB400, ACQ0_CYC, CONV_CYC, 1, 2 * SET0_CYC);
    rdChk(OFS_RES_BASE + 4'h4, 16'h0200, 16'hFFFF);
    rdChk(OFS_CTL_THR, 16'h0002, 16'h0003);
    bit1(irqOut_n, 1'b0);
    wrReg(OFS_CTL_THR, 16'h0000);
    abLevel <= 12'h010;
    runSeq(16'hA400, ACQ0_CYC, CONV_CYC, 1, 2 * SET0_CYC);
    rdChk(OFS_CTL_THR, 16'h0001, 16'h0003);
    bit1(irqOut_n, 1'b1);
    wrReg(OFS_CTL_THR, 16'h0000);
    abLevel <= 12'h100;
    runSeq(16'hB400, ACQ0_CYC, CONV_CYC, 1, 2 * SET0_CYC);
    rdChk(OFS_CTL_THR, 16'h0000, 16'h0003);
  endtask

  task automatic median();
    wrReg(OFS_CTL_TWO, 16'h0020);
    runSeq(16'h3500, 4 * ACQ1_CYC, 4 * CONV_CYC, 4, 2 * SET0_CYC + 4 * SORT_CYC);
    runSeq(16'h1400, 4 * ACQ3_CYC, 4 * CONV_CYC, 4, 2 * SET0_CYC + 4 * SORT_CYC);
  endtask

  // master mode on the aux slot: gap between acquisitions is convert, two settles and timer
  task automatic masterRun();
    int gap;
    gap = 0;
    wrReg(OFS_CTL_TWO, 16'h0000);
    wrReg(OFS_CTL_THR, 16'h0040);
    wrReg(OFS_CTL_ONE, 16'h0C01);
    waitN(1);
    while (frontAcquire !== 1'b1 && gap < 2000)
    begin
      gap++;
      waitN(1);
    end
    while (frontAcquire === 1'b1)
      waitN(1);
    gap = 0;
    while (frontAcquire !== 1'b1 && gap < 2000)
    begin
      gap++;
      waitN(1);
    end
    chk(gap[15:0], 16'(CONV_CYC + 2 * SET0_CYC + TUNIT_CYC));
    wrReg(OFS_CTL_ONE, 16'h0000);
    waitN(1);
    bit1(seqBusy, 1'b0);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // a hang counts as a mismatch
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errTotal++;
      completeRun();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    regReq = '0;
    abLevel = 12'h000;
    pinLevel = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    resetMap();
    pinOutput();
    pinInput();
    limits();
    median();
    masterRun();
    completeRun();
  end
endmodule

/* File: src/touch_adc_limit_gpio_regs.sv */
// register map, limit comparison, general-purpose pin and conversion sequencer timing
// assumes the analog front end runs on sys_clk and presents its sample on sampleIn
// Summary of operation
// - aux and battery results compared to limits; alarm on interrupt when enabled.
// - one shared upper limit at 0x04, one shared lower limit at 0x05.
// - each aux or battery result above upper or below lower limit sets high or low status bit in third control.
// - a limit source with its enable bit cleared never reaches the interrupt.
// - pin is general purpose only while bit 13 is 1; else config ignored.
// - pin data value lives in bit 12 of second control register.
// - bit 11 zero drives pin from data; one makes pin an input updating data.
// - host writes to the data bit are ignored while the pin is an input.
// - polarity one passes values straight between pin and data bit.
// - polarity zero inverts between pin and data bit both ways.
// - pin may raise the interrupt only while third control bit 12 is 0.
// - pin interrupt needs input direction, data bit set and interrupt enabled.
// - pin interrupt holds until pin level, enable, direction, polarity or third control bit 12 changes.
// - settle before each screen channel; non-screen-only sequence settles once first.
// - one more settle always follows the last channel.
// - measurement is acquisition plus 7.5 us plus 2 us sort unless median off.
// - acquisition 2, 4, 8 or 16 us by setting; temperature always 16 us.
// - each channel repeats 1, 4, 8 or 16 measurements per median setting.
// - period is opening and screen-channel settles plus channel time, final settle, then timer.
// - second control resets to 0x4040, other writable registers to zero.
// - results at 0x08 to 0x0D are read only and reset to zero.
// - manual code 011 selects auxiliary input, 010 selects battery input.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps

module touch_adc_limit_gpio_regs
  import touch_ctl_pkg::*;
#(
  parameter int unsigned SET2_CYC = 5000,
  parameter int unsigned SET3_CYC = 10240,
  parameter logic [15:0] REV_ID   = 16'h0A5C  // arbitrary identity value
)
(
  input  wire logic        sys_clk,
  input  wire reg_req_t    regReq,
  output logic [15:0]      regRdata,
  input  wire logic        gpioIn,
  output logic             gpioOut,
  output logic             gpioOe,
  input  wire logic [11:0] sampleIn,
  output logic [2:0]       frontChannel,
  output logic             frontAcquire,
  output logic             frontConvert,
  output logic             seqBusy,
  output logic             irqOut_n,
  input  wire logic        rst_n
);

  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_ACQ, S_CONV, S_SORT, S_FINAL, S_TIMER} seq_t;

  logic [15:0] ctlOne_r, ctlTwo_r, ctlThr_r, spare_r;
  logic [15:0] abUpper_r, abLower_r, tUpper_r, tLower_r;
  logic [15:0] results_r [6];
  logic [15:0] regRdata_r;
  logic        gpioSyncA_r, gpioSyncB_r;
  logic        gpioOut_r, gpioOe_r, irqOut_n_r, startReq_r;
  seq_t        state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0]  chan_r;
  logic [4:0]  meas_r;
  logic [5:0]  seqMask_r;
  logic [11:0] sample_r;

  // decoded controls
  logic        gpioEn, gpioDir, gpioPol, gpioData, intEn;
  logic [1:0]  medSel;
  logic [5:0]  manualMask, startMask;
  logic        chanDone;
  logic [2:0]  nextChan;
  logic [15:0] storeVal;
  logic        abStore, hiHit, loHit;
  logic        wrOne, wrTwo, wrThr;
  logic        limitIrq, gpioIrq;

  assign gpioEn   = ctlTwo_r[C2_GPIO_EN];
  assign gpioDir  = ctlTwo_r[C2_GPIO_DIR];
  assign gpioPol  = ctlTwo_r[C2_PIN_POLARITY_BIT];
  assign gpioData = ctlTwo_r[C2_GPIO_DAT];
  assign intEn    = ctlOne_r[C1_INT_EN];
  assign medSel   = ctlTwo_r[C2_MED_LSB +: 2];
  assign wrOne    = regReq.wr && regReq.addr == OFS_CTL_ONE;
  assign wrTwo    = regReq.wr && regReq.addr == OFS_CTL_TWO;
  assign wrThr    = regReq.wr && regReq.addr == OFS_CTL_THR;

  function automatic logic [5:0] chanToMask(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    case (code)
      3'h7:           m = 6'h01;
      3'h6:           m = 6'h02;
      3'h5:           m = 6'h04;
      3'h4:           m = 6'h08;
      CH_AUX, CH_BATT: m = 6'h10;
      CH_TEMP:        m = 6'h20;
      default:        m = 6'h00;
    endcase
    return m;
  endfunction

  function automatic logic [2:0] findChan(input logic [5:0] m, input logic [2:0] from);
    logic [2:0] f;
    f = NO_CHAN;
    for (int i = 5; i >= 0; i--)
    begin
      if (m[i] && 3'(i) >= from)
        f = 3'(i);
    end
    return f;
  endfunction

  function automatic logic [CNT_W-1:0] acqLoad(input logic [1:0] sel, input logic [2:0] ch);
    int unsigned c;
    c = ACQ3_CYC;
    if (ch != T_SLOT)
    begin
      case (sel)
        2'h0:    c = ACQ0_CYC;
        2'h1:    c = ACQ1_CYC;
        2'h2:    c = ACQ2_CYC;
        default: c = ACQ3_CYC;
      endcase
    end
    return CNT_W'(c - 1);
  endfunction

  function automatic logic [CNT_W-1:0] settleLoad(input logic [1:0] sel);
    int unsigned c;
    case (sel)
      2'h0:    c = SET0_CYC;
      2'h1:    c = SET1_CYC;
      2'h2:    c = SET2_CYC;
      default: c = SET3_CYC;
    endcase
    return CNT_W'(c - 1);
  endfunction

  function automatic logic [4:0] measLoad(input logic [1:0] sel);
    logic [4:0] n;
    case (sel)
      2'h0:    n = 5'h00;
      2'h1:    n = 5'h03;
      2'h2:    n = 5'h07;
      default: n = 5'h0F;
    endcase
    return n;
  endfunction

  assign manualMask = chanToMask(ctlOne_r[C1_CHAN_LSB +: 3]);
  assign startMask  = (ctlOne_r[C1_MODE_LSB +: 2] == MODE_SINGLE) ? manualMask
                                                                 : ctlThr_r[C3_SEQ_LSB +: 6];

  // a channel ends after its last conversion, or after the sort that follows it
  assign chanDone = meas_r == 5'h00 && cnt_r == '0
                    && ((state_r == S_CONV && medSel == 2'h0) || state_r == S_SORT);
  assign nextChan = (chan_r == T_SLOT) ? NO_CHAN : findChan(seqMask_r, chan_r + 3'h1);
  assign storeVal = {4'h0, (state_r == S_CONV) ? sampleIn : sample_r};
  assign abStore  = chanDone && chan_r == AB_SLOT;
  assign hiHit    = abStore && storeVal > abUpper_r;
  assign loHit    = abStore && storeVal < abLower_r;

  // pin input synchroniser
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpioSyncA_r <= 1'b0;
      gpioSyncB_r <= 1'b0;
    end
    else
    begin
      gpioSyncA_r <= gpioIn;
      gpioSyncB_r <= gpioSyncA_r;
    end
  end

  // plain writable registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spare_r   <= ZERO_RST;
      ctlOne_r  <= ZERO_RST;
      abUpper_r <= ZERO_RST;
      abLower_r <= ZERO_RST;
      tUpper_r  <= ZERO_RST;
      tLower_r  <= ZERO_RST;
    end
    else if (regReq.wr)
    begin
      case (regReq.addr)
        OFS_SPARE:    spare_r   <= regReq.wdata;
        OFS_CTL_ONE:  ctlOne_r  <= regReq.wdata;
        OFS_AB_UPPER: abUpper_r <= regReq.wdata;
        OFS_AB_LOWER: abLower_r <= regReq.wdata;
        OFS_T_UPPER:  tUpper_r  <= regReq.wdata;
        OFS_T_LOWER:  tLower_r  <= regReq.wdata;
        default:      ;
      endcase
    end
  end

  // second control: pin data follows the pin while it is an input
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctlTwo_r <= CTL_TWO_RST;
    else
    begin
      if (wrTwo)
        ctlTwo_r <= regReq.wdata;
      if (gpioEn && gpioDir)
        ctlTwo_r[C2_GPIO_DAT] <= gpioPol ? gpioSyncB_r : ~gpioSyncB_r;
      else if (wrTwo)
        ctlTwo_r[C2_GPIO_DAT] <= regReq.wdata[C2_GPIO_DAT];
    end
  end

  // third control: status written by host, set by comparisons; set wins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctlThr_r <= ZERO_RST;
    else
    begin
      if (wrThr)
        ctlThr_r <= regReq.wdata;
      if (hiHit)
        ctlThr_r[C3_HI_STAT] <= 1'b1;
      if (loHit)
        ctlThr_r[C3_LO_STAT] <= 1'b1;
    end
  end

  // conversion results, read only from the host side
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 6; i++)
        results_r[i] <= ZERO_RST;
    end
    else if (chanDone)
      results_r[chan_r] <= storeVal;
  end

  // read data, valid the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata_r <= ZERO_RST;
    else if (regReq.rd)
    begin
      case (regReq.addr)
        OFS_SPARE:    regRdata_r <= spare_r;
        OFS_CTL_ONE:  regRdata_r <= ctlOne_r;
        OFS_CTL_TWO:  regRdata_r <= ctlTwo_r;
        OFS_CTL_THR:  regRdata_r <= ctlThr_r;
        OFS_AB_UPPER: regRdata_r <= abUpper_r;
        OFS_AB_LOWER: regRdata_r <= abLower_r;
        OFS_T_UPPER:  regRdata_r <= tUpper_r;
        OFS_T_LOWER:  regRdata_r <= tLower_r;
        OFS_REV_ID:   regRdata_r <= REV_ID;
        default:
        begin
          if (regReq.addr >= OFS_RES_BASE && regReq.addr <= OFS_RES_LAST)
            regRdata_r <= results_r[3'(regReq.addr - OFS_RES_BASE)];
          else
            regRdata_r <= ZERO_RST;
        end
      endcase
    end
    else
      regRdata_r <= ZERO_RST;
  end

  // pin drive and interrupt, both registered
  assign limitIrq = (ctlThr_r[C3_HI_STAT] && ctlThr_r[C3_HI_EN])
                    || (ctlThr_r[C3_LO_STAT] && ctlThr_r[C3_LO_EN]);
  // level source: it falls when the pin level, the enable, the direction, the polarity or disable bit 12 moves
  assign gpioIrq  = gpioEn && gpioDir && gpioData && !ctlThr_r[C3_ALERT_DIS];

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpioOut_r  <= 1'b0;
      gpioOe_r   <= 1'b0;
      irqOut_n_r <= 1'b1;
    end
    else
    begin
      gpioOe_r   <= gpioEn && !gpioDir;
      gpioOut_r  <= gpioEn && !gpioDir && (gpioPol ? gpioData : ~gpioData);
      irqOut_n_r <= !(intEn && (limitIrq || gpioIrq));
    end
  end

  // a control-one write with a non-zero mode starts a run next cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      startReq_r <= 1'b0;
    else
      startReq_r <= wrOne && regReq.wdata[C1_MODE_LSB +: 2] != MODE_OFF;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sample_r <= 12'h000;
    else if (state_r == S_CONV && cnt_r == '0)
      sample_r <= sampleIn;
  end

  // sequencer timing
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r   <= S_IDLE;
      cnt_r     <= '0;
      chan_r    <= 3'h0;
      meas_r    <= 5'h00;
      seqMask_r <= 6'h00;
    end
    else if (wrOne && regReq.wdata[C1_MODE_LSB +: 2] == MODE_OFF)
      state_r <= S_IDLE;
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          if (startReq_r && findChan(startMask, 3'h0) != NO_CHAN)
          begin
            // screen channels come first, so the opening settle always applies
            seqMask_r <= startMask;
            chan_r    <= findChan(startMask, 3'h0);
            cnt_r     <= settleLoad(ctlTwo_r[C2_SET_LSB +: 2]);
            state_r   <= S_SETTLE;
          end
        end
        S_SETTLE:
        begin
          if (cnt_r == '0)
          begin
            meas_r  <= measLoad(medSel);
            cnt_r   <= acqLoad(ctlOne_r[C1_ACQ_LSB +: 2], chan_r);
            state_r <= S_ACQ;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        S_ACQ:
        begin
          if (cnt_r == '0)
          begin
            cnt_r   <= CNT_W'(CONV_CYC - 1);
            state_r <= S_CONV;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        S_CONV, S_SORT:
        begin
          if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
          else if (state_r == S_CONV && medSel != 2'h0)
          begin
            cnt_r   <= CNT_W'(SORT_CYC - 1);
            state_r <= S_SORT;
          end
          else if (meas_r != 5'h00)
          begin
            meas_r  <= meas_r - 5'h01;
            cnt_r   <= acqLoad(ctlOne_r[C1_ACQ_LSB +: 2], chan_r);
            state_r <= S_ACQ;
          end
          else if (nextChan == NO_CHAN)
          begin
            cnt_r   <= settleLoad(ctlTwo_r[C2_SET_LSB +: 2]);
            state_r <= S_FINAL;
          end
          else
          begin
            chan_r <= nextChan;
            if (nextChan < AB_SLOT)
            begin
              cnt_r   <= settleLoad(ctlTwo_r[C2_SET_LSB +: 2]);
              state_r <= S_SETTLE;
            end
            else
            begin
              meas_r  <= measLoad(medSel);
              cnt_r   <= acqLoad(ctlOne_r[C1_ACQ_LSB +: 2], nextChan);
              state_r <= S_ACQ;
            end
          end
        end
        S_FINAL:
        begin
          if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
          else if (ctlOne_r[C1_MODE_LSB +: 2] != MODE_MASTER)
            state_r <= S_IDLE;
          else
          begin
            cnt_r   <= CNT_W'(ctlOne_r[C1_TMR_LSB +: 8] * TUNIT_CYC);
            state_r <= S_TIMER;
          end
        end
        S_TIMER:
        begin
          // stop at one so the wait is exactly the programmed interval; zero still costs a cycle
          if (cnt_r > CNT_W'(1))
            cnt_r <= cnt_r - 1'b1;
          else
          begin
            // master mode reruns with the channel list as it stands now
            seqMask_r <= startMask;
            chan_r    <= findChan(startMask, 3'h0);
            cnt_r     <= settleLoad(ctlTwo_r[C2_SET_LSB +: 2]);
            state_r   <= (findChan(startMask, 3'h0) == NO_CHAN) ? S_IDLE : S_SETTLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  assign regRdata     = regRdata_r;
  assign gpioOut      = gpioOut_r;
  assign gpioOe       = gpioOe_r;
  assign irqOut_n     = irqOut_n_r;
  assign frontChannel = chan_r;
  assign frontAcquire = state_r == S_ACQ;
  assign frontConvert = state_r == S_CONV;
  assign seqBusy      = state_r != S_IDLE;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  pin_drive_a: assert property (gpioEn && !gpioDir |=> gpioOe
                                && gpioOut == $past(gpioPol ? gpioData : ~gpioData))
    else $error("pin output does not follow data and polarity");
  pin_released_a: assert property (!gpioEn |=> !gpioOe)
    else $error("pin driven while general purpose mode is off");
  pin_capture_a: assert property (gpioEn && gpioDir
                                  |=> gpioData == $past(gpioPol ~^ gpioSyncB_r))
    else $error("input pin level not captured into data bit");
  write_ignored_a: assert property (wrTwo && gpioEn && gpioDir && gpioPol
                                    && !gpioSyncB_r |=> !gpioData)
    else $error("host write reached data bit of an input pin");
  high_status_a: assert property (hiHit |=> ctlThr_r[C3_HI_STAT])
    else $error("high violation did not set status");
  low_status_a: assert property (abStore && storeVal < abLower_r |=> ctlThr_r[C3_LO_STAT])
    else $error("low violation did not set status");
  limit_masked_a: assert property (!gpioIrq && !ctlThr_r[C3_HI_EN]
                                   && !ctlThr_r[C3_LO_EN] |=> irqOut_n)
    else $error("masked limit source reached interrupt");
  pin_irq_a: assert property (intEn && gpioIrq |=> !irqOut_n)
    else $error("pin interrupt not raised");
  temp_acq_a: assert property (state_r == S_SETTLE && cnt_r == '0 && chan_r == T_SLOT
                               |=> state_r == S_ACQ && cnt_r == CNT_W'(ACQ3_CYC - 1))
    else $error("temperature acquisition not fixed at longest time");
  no_sort_a: assert property (state_r == S_CONV && cnt_r == '0
                              && medSel == 2'h0 |=> state_r != S_SORT)
    else $error("sort inserted with median filter off");
  final_settle_a: assert property (chanDone && nextChan == NO_CHAN |=> state_r == S_FINAL)
    else $error("last channel not followed by settle");

  aux_store_c: cover property (abStore && hiHit);
  pin_irq_c: cover property (gpioIrq && intEn ##1 !irqOut_n);
  timer_run_c: cover property (state_r == S_TIMER ##1 state_r == S_SETTLE);
endmodule

/* File: src/touch_ctl_pkg.sv */
// constants, register map and carrier types for the touch digitiser control block
// assumes a single 10 MHz system clock and a host register port on that clock
package touch_ctl_pkg;

  localparam int unsigned CLK_MHZ = 10;

  // register offsets (word index on the plain register port)
  localparam logic [3:0] OFS_SPARE    = 4'h0;
  localparam logic [3:0] OFS_CTL_ONE  = 4'h1;
  localparam logic [3:0] OFS_CTL_TWO  = 4'h2;
  localparam logic [3:0] OFS_CTL_THR  = 4'h3;
  localparam logic [3:0] OFS_AB_UPPER = 4'h4;
  localparam logic [3:0] OFS_AB_LOWER = 4'h5;
  localparam logic [3:0] OFS_T_UPPER  = 4'h6;
  localparam logic [3:0] OFS_T_LOWER  = 4'h7;
  localparam logic [3:0] OFS_RES_BASE = 4'h8;
  localparam logic [3:0] OFS_RES_LAST = 4'hD;
  localparam logic [3:0] OFS_REV_ID   = 4'hE;

  localparam logic [15:0] CTL_TWO_RST = 16'h4040;
  localparam logic [15:0] ZERO_RST    = 16'h0000;

  // first control register fields
  localparam int unsigned C1_INT_EN   = 15;
  localparam int unsigned C1_CHAN_LSB = 12;
  localparam int unsigned C1_MODE_LSB = 10;
  localparam int unsigned C1_ACQ_LSB  = 8;
  localparam int unsigned C1_TMR_LSB  = 0;
  // second control register fields
  localparam int unsigned C2_GPIO_EN  = 13;
  localparam int unsigned C2_GPIO_DAT = 12;
  localparam int unsigned C2_GPIO_DIR = 11;
  localparam int unsigned C2_PIN_POLARITY_BIT = 10;
  localparam int unsigned C2_MED_LSB  = 5;
  localparam int unsigned C2_SET_LSB  = 0;
  // third control register fields
  localparam int unsigned C3_ALERT_DIS = 12;
  localparam int unsigned C3_HI_EN     = 9;
  localparam int unsigned C3_LO_EN     = 8;
  localparam int unsigned C3_SEQ_LSB   = 2;
  localparam int unsigned C3_HI_STAT   = 1;
  localparam int unsigned C3_LO_STAT   = 0;

  // manual channel codes, then internal slot numbers
  localparam logic [2:0] CH_AUX  = 3'h3;
  localparam logic [2:0] CH_BATT = 3'h2;
  localparam logic [2:0] CH_TEMP = 3'h1;
  localparam logic [2:0] NO_CHAN = 3'h6;
  localparam logic [2:0] AB_SLOT = 3'h4;
  localparam logic [2:0] T_SLOT  = 3'h5;

  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_MASTER = 2'h3;

  // timing, in ns, then in clock cycles
  localparam int unsigned ACQ0_NS = 2000;
  localparam int unsigned ACQ1_NS = 4000;
  localparam int unsigned ACQ2_NS = 8000;
  localparam int unsigned ACQ3_NS = 16000;
  localparam int unsigned CONV_NS = 7500;
  localparam int unsigned SORT_NS = 2000;
  localparam int unsigned SET0_NS = 10000;
  localparam int unsigned SET1_NS = 100000;
  localparam int unsigned TUNIT_NS = 36800;
  localparam int unsigned ACQ0_CYC  = (ACQ0_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACQ1_CYC  = (ACQ1_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACQ2_CYC  = (ACQ2_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACQ3_CYC  = (ACQ3_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC  = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SORT_CYC  = (SORT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SET0_CYC  = (SET0_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SET1_CYC  = (SET1_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TUNIT_CYC = (TUNIT_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned CNT_W = 17;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage
